// ### fpt_pkg.sv
package fpt_pkg;

  localparam int FPT_DATA_W = 32;
  localparam int FPT_ADDR_W = 12;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [11:0] FPT_OFF_ADDR = 12'h000;
  localparam logic [11:0] FPT_OFF_DATA = 12'h004;
  localparam logic [11:0] FPT_OFF_CTRL = 12'h008;
  localparam logic [11:0] FPT_OFF_RAW = 12'h00C;
  localparam logic [11:0] FPT_OFF_MASK = 12'h010;
  localparam logic [11:0] FPT_OFF_USEC = 12'h140;
  localparam logic [11:0] FPT_OFF_READ_POL0 = 12'h200;
  localparam logic [11:0] FPT_OFF_READ_POL1 = 12'h204;
  localparam logic [11:0] FPT_OFF_PROG_POL0 = 12'h400;
  localparam logic [11:0] FPT_OFF_PROG_POL1 = 12'h404;
  localparam logic [11:0] FPT_OFF_ARRAY_WIN = 12'h800;

  // Control register layout and key.
  localparam logic [15:0] FPT_CTRL_KEY = 16'hA442;
  localparam int FPT_CTRL_WRITE_BIT = 0;
  localparam int FPT_CTRL_ERASE_BIT = 1;
  localparam int FPT_CTRL_MERASE_BIT = 2;
  localparam int FPT_CTRL_COMMIT_BIT = 3;

  // Status and mask bits.
  localparam int FPT_STAT_ACCESS_BIT = 0;

  // Reset values.
  localparam logic [7:0] FPT_USEC_RESET = 8'h18;
  localparam logic [31:0] FPT_POLICY_FACTORY = 32'hFFFF_FFFF;

  // Durations of the operations in microseconds.
  localparam int FPT_PROG_US = 20;
  localparam int FPT_ERASE_US = 30;
  localparam int FPT_COMMIT_US = 10;

  typedef enum logic [1:0] {
    FPT_OP_PROG,
    FPT_OP_ERASE,
    FPT_OP_MERASE,
    FPT_OP_COMMIT
  } fpt_op_t;

  typedef struct packed {
    logic start;
    fpt_op_t op;
    logic [7:0] us_count;
  } fpt_timer_req_t;

endpackage : fpt_pkg

// ### fpt_us_timer.sv
`timescale 1ns/1ps
module fpt_us_timer
  import fpt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] usec_reload,
  input wire fpt_timer_req_t req,
  output logic busy,
  output logic done
);

  logic [7:0] cyc;
  logic [7:0] us_left;
  wire tick = (cyc == 8'h00);

  // Microsecond ticks come from the reload count, so timing scales with the clock.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cyc <= 8'h00;
      us_left <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (req.start && !busy) begin
        busy <= 1'b1;
        cyc <= usec_reload;
        us_left <= req.us_count;
      end else if (busy) begin
        cyc <= tick ? usec_reload : cyc - 8'h01;
        if (tick) begin
          if (us_left <= 8'h01) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
          us_left <= us_left - 8'h01;
        end
      end
    end
  end

endmodule : fpt_us_timer

// ### fpt_ctrl.sv
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Function
// - Array erases in 1-KB blocks; erase leaves every bit one.
// - Program writes one 32-bit word and can only clear bits.
// - Protection unit is 2 KB, two erase blocks, one program and one read bit.
// - Policy bits live in two pairs of 32-bit registers.
// - Program bit one allows program and erase; zero rejects changes.
// - Read bit zero refuses data reads; fetch still allowed.
// - Execute-only units reject changes and serve only fetches.
// - Read-only units reject changes yet allow reads and fetches.
// - Program one, read zero: write, erase, execute allowed, reads refused.
// - Both bits one: everything allowed.
// - Blocked change raises interrupt only when access-fault mask set.
// - Blocked data read returns zero, optionally raises interrupt.
// - Operations are timed from the cycles-per-microsecond reload value.
// - Reload value resets to suit the maximum clock rate.
// - Factory policy bits are all one.
// - Policy writes act at once, become permanent only on commit.
// - Uncommitted cleared bits revert at power-on reset.
// - Committed policy storage can only clear bits, never set them.
// - Keyed commit command starts commit; completion polled in control register.
module fpt_ctrl
  import fpt_pkg::*;
#(
  parameter int UNITS = 64,
  parameter int WORDS = 8192
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fetch_req,
  input wire logic [16:0] fetch_addr,
  output logic [31:0] fetch_data,
  output logic fetch_ok,
  output logic irq
);

  localparam int AW = $clog2(WORDS);

  // Policy storage: live copy and committed copy; power-on reloads committed.
  logic [UNITS-1:0] prog_live, read_live;
  // Committed copy never resets: it stands for the nonvolatile store and leaves power-on at factory ones.
  logic [UNITS-1:0] prog_nv = {(UNITS/32){FPT_POLICY_FACTORY}};
  logic [UNITS-1:0] read_nv = {(UNITS/32){FPT_POLICY_FACTORY}};
  logic [31:0] mem [WORDS];
  logic [31:0] addr_reg, data_reg;
  logic [3:0] ctrl_bits;
  logic [7:0] microsecond_reload;
  logic access_raw, access_fault_mask;
  fpt_timer_req_t treq;
  logic t_busy, t_done;
  logic first_init;

  // Unit index from a byte address: 2 KB per unit.
  function automatic int unsigned unit_of(input logic [31:0] a);
    unit_of = (a[31:11] < UNITS) ? 32'(a[31:11]) : 0;
  endfunction : unit_of

  wire [AW-1:0] word_idx = addr_reg[AW+1:2];
  wire prog_guard = prog_live[unit_of(addr_reg)];
  wire ctrl_key_ok = s_axi_wdata[31:16] == FPT_CTRL_KEY;

  // AXI write: accept address and data in either order, answer after both.
  logic aw_held, w_held;
  logic [11:0] aw_q;
  logic [31:0] w_q;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire aw_now = s_axi_awvalid && s_axi_awready;
  wire w_now = s_axi_wvalid && s_axi_wready;
  wire [11:0] waddr = aw_held ? aw_q : s_axi_awaddr;
  wire [31:0] wdat = w_held ? w_q : s_axi_wdata;
  wire wr_go = (aw_held || aw_now) && (w_held || w_now);

  // Command decode; a new command is ignored while one runs.
  wire wr_ctrl = wr_go && waddr == FPT_OFF_CTRL && (w_held ? w_q[31:16] == FPT_CTRL_KEY : ctrl_key_ok);
  wire cmd_ok = wr_ctrl && !t_busy && ctrl_bits == 4'h0;
  wire cmd_prog = cmd_ok && wdat[FPT_CTRL_WRITE_BIT];
  wire cmd_erase = cmd_ok && !wdat[FPT_CTRL_WRITE_BIT] && wdat[FPT_CTRL_ERASE_BIT];
  wire cmd_merase = cmd_ok && wdat[3:0] == 4'h4;
  wire cmd_commit = cmd_ok && wdat[3:0] == 4'h8;
  wire cmd_any = cmd_prog || cmd_erase || cmd_merase || cmd_commit;
  wire blocked = (cmd_prog || cmd_erase) && !prog_guard;
  wire merase_blocked = cmd_merase && !(&prog_live);

  // Array read window decode and read guard.
  wire rd_go = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !s_axi_rvalid;
  wire read_guard = read_live[unit_of(addr_reg)];
  wire rd_array = s_axi_araddr == FPT_OFF_ARRAY_WIN;
  wire rd_refused = rd_array && !read_guard;

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (aw_now && !wr_go) aw_held <= 1'b1;
      if (w_now && !wr_go) w_held <= 1'b1;
      if (aw_now) aw_q <= s_axi_awaddr;
      if (w_now) w_q <= s_axi_wdata;
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'b00;

  wire wr_hit = wr_go;
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_reg <= 32'h0000_0000;
      data_reg <= 32'h0000_0000;
      access_fault_mask <= 1'b0;
      microsecond_reload <= FPT_USEC_RESET;
      first_init <= 1'b1;
      // Reset models power-on: uncommitted clears vanish.
      prog_live <= '1;
      read_live <= '1;
    end else begin
      if (first_init) begin
        prog_live <= prog_nv;
        read_live <= read_nv;
        first_init <= 1'b0;
      end else if (wr_hit) begin
        case (waddr)
          FPT_OFF_ADDR: addr_reg <= wdat;
          FPT_OFF_DATA: data_reg <= wdat;
          FPT_OFF_MASK: access_fault_mask <= wdat[FPT_STAT_ACCESS_BIT];
          FPT_OFF_USEC: microsecond_reload <= wdat[7:0];
          // Live writes act at once on the guards.
          FPT_OFF_PROG_POL0: prog_live[31:0] <= wdat;
          FPT_OFF_PROG_POL1: prog_live[UNITS-1:32] <= wdat[UNITS-33:0];
          FPT_OFF_READ_POL0: read_live[31:0] <= wdat;
          FPT_OFF_READ_POL1: read_live[UNITS-1:32] <= wdat[UNITS-33:0];
          default: ;
        endcase
      end
    end
  end

  // Control bits stay set while the operation runs, so software can poll.
  // Erase bits stay up through the sweep, so no command can overlap it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_bits <= 4'h0;
      access_raw <= 1'b0;
      treq <= '0;
    end else begin
      treq.start <= 1'b0;
      if (cmd_any && !blocked && !merase_blocked) begin
        ctrl_bits <= wdat[3:0];
        treq.start <= 1'b1;
        treq.op <= cmd_prog ? FPT_OP_PROG : cmd_commit ? FPT_OP_COMMIT : cmd_merase ? FPT_OP_MERASE : FPT_OP_ERASE;
        treq.us_count <= cmd_prog ? 8'(FPT_PROG_US) : cmd_commit ? 8'(FPT_COMMIT_US) : 8'(FPT_ERASE_US);
      end else if ((t_done && (treq.op == FPT_OP_PROG || treq.op == FPT_OP_COMMIT)) || er_left == (AW+1)'(1)) begin
        ctrl_bits <= 4'h0;
      end
      // Set wins over a write-one clear in the same cycle.
      if (blocked || merase_blocked || (rd_go && rd_refused)) access_raw <= 1'b1;
      else if (wr_hit && waddr == FPT_OFF_RAW && wdat[FPT_STAT_ACCESS_BIT]) access_raw <= 1'b0;
    end
  end

  // Commit only ANDs live bits in, so the store can lose ones but never gain them.
  always_ff @(posedge mclk) begin
    if (t_done && treq.op == FPT_OP_COMMIT) begin
      prog_nv <= prog_nv & prog_live;
      read_nv <= read_nv & read_live;
    end
  end

  // Erase sweeps one word per cycle after the timed wait; blocks are 256 words.
  logic [AW-1:0] er_idx;
  logic [AW:0] er_left;
  always_ff @(posedge mclk) begin
    if (rst) begin
      er_idx <= '0;
      er_left <= '0;
    end else if (t_done && treq.op == FPT_OP_ERASE) begin
      er_idx <= {word_idx[AW-1:8], 8'h00};
      er_left <= (AW+1)'(256);
    end else if (t_done && treq.op == FPT_OP_MERASE) begin
      er_idx <= '0;
      er_left <= (AW+1)'(WORDS);
    end else if (er_left != '0) begin
      er_idx <= er_idx + 1'b1;
      er_left <= er_left - 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (er_left != '0) begin
      mem[er_idx] <= 32'hFFFF_FFFF;
    end else if (t_done && treq.op == FPT_OP_PROG) begin
      mem[word_idx] <= mem[word_idx] & data_reg;
    end
  end

  fpt_us_timer u_timer (
    .mclk(mclk),
    .rst(rst),
    .usec_reload(microsecond_reload),
    .req(treq),
    .busy(t_busy),
    .done(t_done)
  );

  // Register and array-window reads.
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      FPT_OFF_ADDR: rd_val = addr_reg;
      FPT_OFF_DATA: rd_val = data_reg;
      FPT_OFF_CTRL: rd_val = {28'h0, ctrl_bits};
      FPT_OFF_RAW: rd_val = {31'h0, access_raw};
      FPT_OFF_MASK: rd_val = {31'h0, access_fault_mask};
      FPT_OFF_USEC: rd_val = {24'h0, microsecond_reload};
      FPT_OFF_PROG_POL0: rd_val = prog_live[31:0];
      FPT_OFF_PROG_POL1: rd_val = 32'(prog_live[UNITS-1:32]);
      FPT_OFF_READ_POL0: rd_val = read_live[31:0];
      FPT_OFF_READ_POL1: rd_val = 32'(read_live[UNITS-1:32]);
      FPT_OFF_ARRAY_WIN: rd_val = read_guard ? mem[word_idx] : 32'h0000_0000;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_rresp = 2'b00;

  // Fetches ignore the read guard: every unit may execute.
  always_ff @(posedge mclk) begin
    if (rst) begin
      fetch_data <= 32'h0000_0000;
      fetch_ok <= 1'b0;
    end else begin
      fetch_ok <= fetch_req;
      if (fetch_req) fetch_data <= mem[fetch_addr[AW+1:2]];
    end
  end

  assign irq = access_raw && access_fault_mask;

endmodule : fpt_ctrl

// ### fpt_ctrl_checker.sv
`timescale 1ns/1ps
module fpt_ctrl_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fetch_req,
  input wire logic fetch_ok,
  input wire logic irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  chk_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data did not follow the address.");
  chk_r_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("Read data appeared without a request.");
  chk_ar_single: assert property (s_axi_arvalid && s_axi_arready |-> !s_axi_rvalid)
    else $error("Read address taken while data pending.");
  chk_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read data repeated.");
  chk_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response repeated.");
  chk_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("Write response not okay.");
  chk_fetch_ok: assert property (fetch_req |=> fetch_ok)
    else $error("Fetch was not answered.");
  chk_fetch_idle: assert property (!fetch_req |=> !fetch_ok)
    else $error("Fetch answer without request.");
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(irq));
  cover property (fetch_req ##1 fetch_ok);
endmodule : fpt_ctrl_checker

bind fpt_ctrl fpt_ctrl_checker u_chk (.mclk, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .fetch_req, .fetch_ok, .irq);

// ### fpt_fetch_model.sv
`timescale 1ns/1ps
module fpt_fetch_model (
  input wire logic mclk,
  input wire logic fetch_ok,
  input wire logic [31:0] fetch_data,
  output logic fetch_req,
  output logic [16:0] fetch_addr
);
  initial begin
    fetch_req = 1'h0;
    fetch_addr = 17'h0;
  end
  // The address is inverted when idle so a stale value is never mistaken for a live one.
  task automatic fetch(input logic [16:0] a, output logic [31:0] v);
    @(posedge mclk);
    fetch_req <= 1'h1;
    fetch_addr <= a;
    do @(posedge mclk);
    while (fetch_ok !== 1'h1);
    v = fetch_data;
    fetch_req <= 1'h0;
    fetch_addr <= ~a;
  endtask : fetch
endmodule : fpt_fetch_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench import fpt_pkg::*;;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fetch_req, fetch_ok, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, fetch_data, d;
  logic [16:0] fetch_addr;
  time t0;
  int miscompares = 0, num_checks = 0;
  always #5 mclk = ~mclk;
  fpt_ctrl u_dut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_req, .fetch_addr,
    .fetch_data, .fetch_ok, .irq);
  fpt_fetch_model u_fetch (.mclk, .fetch_ok, .fetch_data, .fetch_req, .fetch_addr);
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  // Ready lines are sampled right after the edge, before that edge's updates land.
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    logic aw_done, w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (!aw_done && s_axi_awready === 1'h1) begin
        aw_done = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_done && s_axi_wready === 1'h1) begin
        w_done = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge mclk);
    while (s_axi_bvalid !== 1'h1);
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge mclk);
    while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge mclk);
    while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
  endtask : axi_rd
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string n);
    logic [31:0] v;
    axi_rd(a, v);
    check(n, v, e);
  endtask : rc
  task automatic fc(input logic [16:0] a, input logic [31:0] e);
    logic [31:0] v;
    u_fetch.fetch(a, v);
    check("fetch", v, e);
  endtask : fc
  task automatic op(input logic [31:0] a, input logic [31:0] v, input logic [15:0] cmd);
    axi_wr(FPT_OFF_ADDR, a);
    axi_wr(FPT_OFF_DATA, v);
    axi_wr(FPT_OFF_CTRL, {FPT_CTRL_KEY, cmd});
    do axi_rd(FPT_OFF_CTRL, d);
    while (d[3:0] !== 4'h0);
  endtask : op
  task automatic do_rst;
    @(posedge mclk);
    rst <= 1'h1;
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    repeat (3) @(posedge mclk);
  endtask : do_rst
  initial begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
  initial begin
    do_rst();
    rc(FPT_OFF_USEC, 32'h18, "usec");
    rc(FPT_OFF_READ_POL0, 32'hFFFFFFFF, "rpol0");
    rc(FPT_OFF_PROG_POL1, 32'hFFFFFFFF, "ppol1");
    // The bench clock runs at 100 MHz, so the reload is 100 minus one.
    axi_wr(FPT_OFF_USEC, 32'h63);
    op(32'h0, 32'h0, 16'h0004);
    fc(17'h0, 32'hFFFFFFFF);
    t0 = $time;
    op(32'h0, 32'hF0F0F0F0, 16'h0001);
    check("prog time", {31'h0, ($time - t0) >= 64'd20000 && ($time - t0) < 64'd20500}, 32'h1);
    rc(FPT_OFF_ARRAY_WIN, 32'hF0F0F0F0, "prog");
    op(32'h0, 32'h0F0FFFFF, 16'h0001);
    rc(FPT_OFF_ARRAY_WIN, 32'h0000F0F0, "clear only");
    op(32'h400, 32'h12345678, 16'h0001);
    op(32'h0, 32'h0, 16'h0002);
    fc(17'h0, 32'hFFFFFFFF);
    fc(17'h400, 32'h12345678);
    axi_wr(FPT_OFF_READ_POL0, 32'hFFFFFFFE);
    axi_wr(FPT_OFF_ADDR, 32'h0);
    rc(FPT_OFF_ARRAY_WIN, 32'h0, "read guard");
    rc(FPT_OFF_RAW, 32'h1, "raw");
    check("irq", {31'h0, irq}, 32'h0);
    fc(17'h0, 32'hFFFFFFFF);
    op(32'h4, 32'h0, 16'h0001);
    fc(17'h4, 32'h0);
    axi_wr(FPT_OFF_RAW, 32'h1);
    rc(FPT_OFF_RAW, 32'h0, "raw clear");
    axi_wr(FPT_OFF_MASK, 32'h1);
    axi_wr(FPT_OFF_PROG_POL0, 32'hFFFFFFFE);
    op(32'h8, 32'h0, 16'h0001);
    fc(17'h8, 32'hFFFFFFFF);
    rc(FPT_OFF_RAW, 32'h1, "raw prog");
    check("irq", {31'h0, irq}, 32'h1);
    axi_wr(FPT_OFF_PROG_POL0, 32'hFFFFFFFC);
    axi_wr(FPT_OFF_READ_POL0, 32'hFFFFFFFF);
    op(32'h400, 32'h0, 16'h0002);
    fc(17'h400, 32'h12345678);
    rc(FPT_OFF_ARRAY_WIN, 32'h12345678, "read only");
    do_rst();
    rc(FPT_OFF_READ_POL0, 32'hFFFFFFFF, "revert r");
    rc(FPT_OFF_PROG_POL0, 32'hFFFFFFFF, "revert p");
    axi_wr(FPT_OFF_PROG_POL0, 32'hFFFFFFFB);
    op(32'h1, 32'h0, 16'h0008);
    do_rst();
    rc(FPT_OFF_PROG_POL0, 32'hFFFFFFFB, "commit");
    axi_wr(FPT_OFF_PROG_POL0, 32'hFFFFFFFF);
    op(32'h1, 32'h0, 16'h0008);
    do_rst();
    rc(FPT_OFF_PROG_POL0, 32'hFFFFFFFB, "no set");
    axi_rd(12'h300, d);
    give_verdict();
  end
endmodule : testbench
